// ===== verilog/hbpg_defines.vh
// Purpose: constants for the half-bridge pattern generator
// Assumes: 40 MHz clock, 32-bit register port
// Notes: offsets are word addresses on the plain register port
//
// What this block does
// RL1: after reset and in off mode both drive outputs stay off.
// RL2: static mode drives each side from its own on/off bit.
// RL3: double-pulse channel select picks pulsed side; the other stays off.
// RL4: double-pulse polarity bit inverts the pulsed output pattern.
// RL5: double pulse is on pulse A, off pause, then on pulse B.
// RL6: one double-pulse sequence per trigger command taken while idle, idle otherwise; a trigger during a sequence is ignored.
// RL7: PWM mode is periodic with a programmable period.
// RL8: duty setting splits the period between high-side and low-side on time.
// RL9: programmable dead time between one side off and the other on.
// RL10: PWM run command starts, stop command halts with both outputs off.
// RL11: a driver fault turns outputs off at once and forces off mode.
// RL12: fault clear pulls the ready/clear line low at least 10 us.
// RL13: driver may refault right after clear; fault line is resampled.
// RL14: after fault shutdown run and trigger are ignored until off mode selected.
// RL15: PWM outputs are complementary and never on together.
`ifndef HBPG_DEFINES_VH
`define HBPG_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define HBPG_REG_CTRL 4'h0
`define HBPG_REG_CMD 4'h1
`define HBPG_REG_PULSE_A 4'h2
`define HBPG_REG_PAUSE 4'h3
`define HBPG_REG_PULSE_B 4'h4
`define HBPG_REG_PERIOD 4'h5
`define HBPG_REG_DUTY 4'h6
`define HBPG_REG_DEAD 4'h7
`define HBPG_REG_STATUS 4'h8
`define HBPG_REG_IRQ_STAT 4'h9
`define HBPG_REG_IRQ_MASK 4'hA

// ----------------------------------------
// field positions
// ----------------------------------------
`define HBPG_CTRL_MODE_LO 0
`define HBPG_CTRL_STATIC_HI 2
`define HBPG_CTRL_STATIC_LO 3
`define HBPG_CTRL_CHAN_HIGH 4
`define HBPG_CTRL_INVERT 5
`define HBPG_CMD_TRIGGER 0
`define HBPG_CMD_RUN 1
`define HBPG_CMD_STOP 2
`define HBPG_CMD_CLEAR 3
`define HBPG_IRQ_FAULT 0
`define HBPG_IRQ_PULSE_DONE 1
`define HBPG_IRQ_CLEAR_DONE 2

// ----------------------------------------
// modes and reset values
// ----------------------------------------
`define HBPG_MODE_OFF 2'h0
`define HBPG_MODE_STATIC 2'h1
`define HBPG_MODE_DOUBLE 2'h2
`define HBPG_MODE_PWM 2'h3
`define HBPG_RST_CTRL 32'h00000000
`define HBPG_RST_TIME 16'h0028
`define HBPG_RST_PERIOD 16'h0FA0
`define HBPG_RST_DUTY 16'h07D0
`define HBPG_RST_DEAD 16'h0028

// ----------------------------------------
// timing
// ----------------------------------------
`define HBPG_CLK_MHZ 40
`define HBPG_CLEAR_LOW_US 10
`define HBPG_CLEAR_CYCLES (`HBPG_CLEAR_LOW_US * `HBPG_CLK_MHZ)

`endif

// ===== verilog/hbpg_pwm_core.v
// Purpose: complementary PWM with dead time
// Assumes: period, duty, dead held stable by the caller while running
// Notes: high side on while count < duty, low side the rest, dead time cut from both
`timescale 1ns/10ps
module hbpg_pwm_core #(
  parameter W = 16
) (
  input wire clk,            // system clock
  input wire reset,          // sync reset, active high
  input wire run,            // generate while high
  input wire [W-1:0] period, // period in cycles
  input wire [W-1:0] duty,   // high-side share in cycles
  input wire [W-1:0] dead,   // dead time in cycles
  output reg highOn,         // high-side drive request
  output reg lowOn           // low-side drive request
);
  reg [W-1:0] count;
  wire [W-1:0] lastCount = (period == {W{1'b0}}) ? {W{1'b0}} : period - {{(W-1){1'b0}}, 1'b1};
  wire highWin = (count >= dead) && (count < duty); // RL8 RL9
  wire lowWin = (count >= duty + dead) && (count <= lastCount); // RL8 RL9

  always @(posedge clk) begin
    if (reset || !run) begin
      count <= {W{1'b0}};
      highOn <= 1'b0;
      lowOn <= 1'b0;
    end else begin
      count <= (count >= lastCount) ? {W{1'b0}} : count + {{(W-1){1'b0}}, 1'b1}; // RL7
      highOn <= highWin; // RL15
      lowOn <= lowWin && !highWin; // RL15
    end
  end
endmodule

// ===== verilog/hbpg_double_pulse.v
// Purpose: one double pulse per trigger taken in idle; triggers while busy are ignored
// Assumes: times in clock cycles, zero length phases pass in one cycle
// Notes: pulse output is unpolarised; the caller applies inversion
`timescale 1ns/10ps
module hbpg_double_pulse #(
  parameter W = 16
) (
  input wire clk,             // system clock
  input wire reset,           // sync reset, active high
  input wire abort,           // drop any pulse in flight
  input wire trigger,         // start one sequence
  input wire [W-1:0] timeA,   // first pulse length
  input wire [W-1:0] timeGap, // pause length
  input wire [W-1:0] timeB,   // second pulse length
  output reg pulse,           // pulse active
  output reg busy,            // sequence running
  output reg done             // one-cycle end pulse
);
  localparam S_IDLE = 2'd0;
  localparam S_A = 2'd1;
  localparam S_GAP = 2'd2;
  localparam S_B = 2'd3;
  reg [1:0] state;
  reg [W-1:0] count;
  wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};

  always @(posedge clk) begin
    if (reset || abort) begin
      state <= S_IDLE;
      count <= {W{1'b0}};
      pulse <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (trigger) begin // RL6
            state <= S_A;
            count <= timeA;
            pulse <= 1'b1;
            busy <= 1'b1;
          end
        end
        S_A: begin
          if (count <= one) begin // RL5
            state <= S_GAP;
            count <= timeGap;
            pulse <= 1'b0;
          end else begin
            count <= count - one;
          end
        end
        S_GAP: begin
          if (count <= one) begin // RL5
            state <= S_B;
            count <= timeB;
            pulse <= 1'b1;
          end else begin
            count <= count - one;
          end
        end
        S_B: begin
          if (count <= one) begin // RL5 RL6
            state <= S_IDLE;
            pulse <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            count <= count - one;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== verilog/hbpg_generator.v
// Purpose: half-bridge pattern generator top with register port
// Assumes: fault line from a pin, synchronised here; one clock
// Notes: read data valid in the cycle after the read strobe
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`include "hbpg_defines.vh"
module hbpg_generator #(
  parameter W = 16,
  parameter CLEAR_CYCLES = `HBPG_CLEAR_CYCLES
) (
  input wire clk,                 // 40 MHz system clock
  input wire reset,               // sync reset, active high
  input wire [3:0] addr,          // register word address
  input wire [31:0] writeData,    // write data
  input wire writeStrobe,         // one-cycle write
  input wire readStrobe,          // one-cycle read
  output reg [31:0] readData,     // read data, cycle after strobe
  input wire fault_line_n,        // driver fault pin, low = fault
  output reg ready_clear_line,    // ready/clear pin drive level
  output reg ready_clear_line_oe_n, // low while driving the pin
  output reg high_side_drive,     // high-side gate input
  output reg low_side_drive,      // low-side gate input
  output wire irq                 // level interrupt
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [1:0] mode;
  reg staticHigh;
  reg staticLow;
  reg chanHigh;
  reg invert;
  reg [W-1:0] pulseA;
  reg [W-1:0] pauseLen;
  reg [W-1:0] pulseB;
  reg [W-1:0] period;
  reg [W-1:0] duty;
  reg [W-1:0] dead;
  reg pwmRun;
  reg lockout;
  reg [2:0] irqStat;
  reg [2:0] irqMask;
  reg faultSync1;
  reg faultSync2;
  reg faultSeen;
  reg clearing;
  reg [15:0] clearCount;

  wire writeCtrl = writeStrobe && (addr == `HBPG_REG_CTRL);
  wire writeCmd = writeStrobe && (addr == `HBPG_REG_CMD);
  wire cmdTrigger = writeCmd && writeData[`HBPG_CMD_TRIGGER];
  wire cmdRun = writeCmd && writeData[`HBPG_CMD_RUN];
  wire cmdStop = writeCmd && writeData[`HBPG_CMD_STOP];
  wire cmdClear = writeCmd && writeData[`HBPG_CMD_CLEAR];
  wire [1:0] newMode = writeData[`HBPG_CTRL_MODE_LO +: 2];
  wire faultNow = faultSync2; // RL13
  wire faultRise = faultNow && !faultSeen;
  wire pwmHigh;
  wire pwmLow;
  wire dpPulse;
  wire dpBusy;
  wire dpDone;
  wire clearDone = clearing && (clearCount == 16'h0001);

  // ----------------------------------------
  // fault pin synchroniser
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      faultSync1 <= 1'b0;
      faultSync2 <= 1'b0;
      faultSeen <= 1'b0;
    end else begin
      faultSync1 <= !fault_line_n;
      faultSync2 <= faultSync1;
      faultSeen <= faultSync2;
    end
  end

  // ----------------------------------------
  // control registers and mode
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      mode <= `HBPG_MODE_OFF; // RL1
      staticHigh <= 1'b0;
      staticLow <= 1'b0;
      chanHigh <= 1'b0;
      invert <= 1'b0;
      pulseA <= `HBPG_RST_TIME;
      pauseLen <= `HBPG_RST_TIME;
      pulseB <= `HBPG_RST_TIME;
      period <= `HBPG_RST_PERIOD;
      duty <= `HBPG_RST_DUTY;
      dead <= `HBPG_RST_DEAD;
      pwmRun <= 1'b0;
      lockout <= 1'b0;
      irqMask <= 3'h0;
    end else begin
      if (writeCtrl) begin
        mode <= newMode;
        staticHigh <= writeData[`HBPG_CTRL_STATIC_HI];
        staticLow <= writeData[`HBPG_CTRL_STATIC_LO];
        chanHigh <= writeData[`HBPG_CTRL_CHAN_HIGH];
        invert <= writeData[`HBPG_CTRL_INVERT];
        if (newMode == `HBPG_MODE_OFF) begin
          lockout <= 1'b0; // RL14
        end
        if (newMode != `HBPG_MODE_PWM) begin
          pwmRun <= 1'b0;
        end
      end
      if (writeStrobe) begin
        case (addr)
          `HBPG_REG_PULSE_A: pulseA <= writeData[W-1:0];
          `HBPG_REG_PAUSE: pauseLen <= writeData[W-1:0];
          `HBPG_REG_PULSE_B: pulseB <= writeData[W-1:0];
          `HBPG_REG_PERIOD: period <= writeData[W-1:0];
          `HBPG_REG_DUTY: duty <= writeData[W-1:0];
          `HBPG_REG_DEAD: dead <= writeData[W-1:0];
          `HBPG_REG_IRQ_MASK: irqMask <= writeData[2:0];
          default: begin
          end
        endcase
      end
      if (cmdRun && mode == `HBPG_MODE_PWM && !lockout) begin
        pwmRun <= 1'b1; // RL10 RL14
      end
      if (cmdStop) begin
        pwmRun <= 1'b0; // RL10
      end
      if (faultNow) begin
        mode <= `HBPG_MODE_OFF; // RL11
        pwmRun <= 1'b0;
        lockout <= 1'b1; // RL14
      end
    end
  end

  // ----------------------------------------
  // pattern engines
  // ----------------------------------------
  hbpg_pwm_core #(.W(W)) pwmCore (
    .clk(clk),
    .reset(reset),
    .run(pwmRun && !faultNow),
    .period(period),
    .duty(duty),
    .dead(dead),
    .highOn(pwmHigh),
    .lowOn(pwmLow)
  );

  hbpg_double_pulse #(.W(W)) dpCore (
    .clk(clk),
    .reset(reset),
    .abort(faultNow || mode != `HBPG_MODE_DOUBLE),
    .trigger(cmdTrigger && mode == `HBPG_MODE_DOUBLE && !lockout), // RL6 RL14
    .timeA(pulseA),
    .timeGap(pauseLen),
    .timeB(pulseB),
    .pulse(dpPulse),
    .busy(dpBusy),
    .done(dpDone)
  );

  // ----------------------------------------
  // output selection
  // ----------------------------------------
  wire dpLevel = dpBusy ? (dpPulse ^ invert) : 1'b0; // RL4
  always @(posedge clk) begin
    if (reset || faultNow) begin
      high_side_drive <= 1'b0; // RL1 RL11
      low_side_drive <= 1'b0;
    end else begin
      case (mode)
        `HBPG_MODE_STATIC: begin
          high_side_drive <= staticHigh; // RL2
          low_side_drive <= staticLow; // RL2
        end
        `HBPG_MODE_DOUBLE: begin
          high_side_drive <= chanHigh ? dpLevel : 1'b0; // RL3
          low_side_drive <= chanHigh ? 1'b0 : dpLevel; // RL3
        end
        `HBPG_MODE_PWM: begin
          high_side_drive <= pwmRun && pwmHigh; // RL10 RL15
          low_side_drive <= pwmRun && pwmLow && !pwmHigh; // RL15
        end
        default: begin
          high_side_drive <= 1'b0; // RL1
          low_side_drive <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // fault clear cycle
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      clearing <= 1'b0;
      clearCount <= 16'h0000;
      ready_clear_line <= 1'b1;
      ready_clear_line_oe_n <= 1'b1;
    end else if (clearing) begin
      clearCount <= clearCount - 16'h0001;
      if (clearDone) begin
        clearing <= 1'b0;
        ready_clear_line_oe_n <= 1'b1; // RL12
      end
    end else if (cmdClear) begin
      clearing <= 1'b1;
      clearCount <= CLEAR_CYCLES[15:0]; // RL12
      ready_clear_line <= 1'b0;
      ready_clear_line_oe_n <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupts and read port
  // ----------------------------------------
  wire [2:0] irqSet = {clearDone, dpDone, faultRise};
  wire [2:0] irqClr = (writeStrobe && addr == `HBPG_REG_IRQ_STAT) ? writeData[2:0] : 3'h0;
  always @(posedge clk) begin
    if (reset) begin
      irqStat <= 3'h0;
    end else begin
      irqStat <= (irqStat & ~irqClr) | irqSet;
    end
  end
  assign irq = |(irqStat & irqMask);

  always @(posedge clk) begin
    if (reset) begin
      readData <= 32'h00000000;
    end else if (readStrobe) begin
      case (addr)
        `HBPG_REG_CTRL: readData <= {26'h0, invert, chanHigh, staticLow, staticHigh, mode};
        `HBPG_REG_PULSE_A: readData <= {{(32-W){1'b0}}, pulseA};
        `HBPG_REG_PAUSE: readData <= {{(32-W){1'b0}}, pauseLen};
        `HBPG_REG_PULSE_B: readData <= {{(32-W){1'b0}}, pulseB};
        `HBPG_REG_PERIOD: readData <= {{(32-W){1'b0}}, period};
        `HBPG_REG_DUTY: readData <= {{(32-W){1'b0}}, duty};
        `HBPG_REG_DEAD: readData <= {{(32-W){1'b0}}, dead};
        `HBPG_REG_STATUS: readData <= {26'h0, clearing, lockout, faultNow, dpBusy,
                                       pwmRun, 1'b0};
        `HBPG_REG_IRQ_STAT: readData <= {29'h0, irqStat};
        `HBPG_REG_IRQ_MASK: readData <= {29'h0, irqMask};
        default: readData <= 32'h00000000;
      endcase
    end else begin
      readData <= 32'h00000000;
    end
  end
endmodule

// ===== verif/hbpg_generator_sva.sv
// Purpose: port checker for the pattern generator
// Assumes: sees only top ports; CLEAR_CYCLES handed on by the bind
// Notes: the mode is tracked from control writes
`timescale 1ns/10ps
module hbpg_generator_sva #(
  parameter CLEAR_CYCLES = 400
) (
  input wire clk,                   // clock
  input wire reset,                 // sync reset
  input wire [3:0] addr,            // address
  input wire [31:0] writeData,      // write data
  input wire writeStrobe,           // write
  input wire readStrobe,            // read
  input wire [31:0] readData,       // read data
  input wire fault_line_n,          // fault pin
  input wire ready_clear_line,      // clear level
  input wire ready_clear_line_oe_n, // clear enable
  input wire high_side_drive,       // high gate
  input wire low_side_drive,        // low gate
  input wire irq                    // interrupt
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  reg [1:0] mode;
  reg [15:0] lowCnt;
  wire wrCtrl = writeStrobe && addr == 4'h0;
  always @(posedge clk) begin
    if (reset)
      mode <= 2'h0;
    else if (wrCtrl)
      mode <= writeData[1:0];
    if (reset || ready_clear_line_oe_n)
      lowCnt <= 16'h0;
    else
      lowCnt <= lowCnt + 16'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  reset_off_a: assert property ($past(reset) |->
      !high_side_drive && !low_side_drive && ready_clear_line_oe_n)
    else $error("drives not off after reset");
  static_level_a: assert property ((wrCtrl && writeData[1:0] == 2'h1 && fault_line_n) ##1
      (!writeStrobe && fault_line_n) [*2] |-> high_side_drive == $past(writeData[2], 2)
      && low_side_drive == $past(writeData[3], 2))
    else $error("static level wrong");
  stop_off_a: assert property (mode == 2'h3 && writeStrobe && addr == 4'h1 && writeData[2]
      |-> ##4 !high_side_drive && !low_side_drive)
    else $error("stop left a drive on");
  fault_off_a: assert property (!fault_line_n [*5] |=> !high_side_drive && !low_side_drive)
    else $error("drive on during fault");
  clear_start_a: assert property (writeStrobe && addr == 4'h1 && writeData[3]
      && ready_clear_line_oe_n |=> !ready_clear_line_oe_n)
    else $error("clear did not start");
  drive_level_a: assert property (!ready_clear_line_oe_n |-> !ready_clear_line)
    else $error("clear line driven high");
  clear_hold_a: assert property ($rose(ready_clear_line_oe_n) |-> lowCnt >= CLEAR_CYCLES)
    else $error("clear pulse too short");
  pwm_overlap_a: assert property (mode == 2'h3 && $past(mode) == 2'h3
      && $past(mode, 2) == 2'h3 |-> !(high_side_drive && low_side_drive))
    else $error("both drives on in pwm");
  read_idle_a: assert property (!readStrobe |=> readData == 32'h0)
    else $error("read data outside read");
endmodule
bind hbpg_generator hbpg_generator_sva #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_sva (
  .clk(clk), .reset(reset), .addr(addr), .writeData(writeData), .writeStrobe(writeStrobe),
  .readStrobe(readStrobe), .readData(readData), .fault_line_n(fault_line_n),
  .ready_clear_line(ready_clear_line), .ready_clear_line_oe_n(ready_clear_line_oe_n),
  .high_side_drive(high_side_drive), .low_side_drive(low_side_drive), .irq(irq));

// ===== verif/hbpg_gate_driver_model.sv
// Purpose: gate driver fault logic seen from its pins
// Assumes: faultCond is the bench's fault condition
// Notes: fault latches until a long enough low on the clear line
`timescale 1ns/10ps
module hbpg_gate_driver_model #(
  parameter MIN_CLEAR = 400
) (
  input wire clk,         // clock
  input wire faultCond,   // fault condition present
  input wire readyLine,   // resolved clear line
  output reg fault_line_n // fault pin, low = fault
);
  integer lowCnt;
  initial begin
    fault_line_n = 1'b1;
    lowCnt = 0;
  end
  always @(posedge clk) begin
    lowCnt <= readyLine ? 0 : lowCnt + 1;
    if (faultCond)
      fault_line_n <= 1'b0;
    else if (readyLine && lowCnt >= MIN_CLEAR)
      fault_line_n <= 1'b1;
  end
endmodule

// ===== verif/hbpg_generator_tb.sv
// Purpose: self-checking bench for the pattern generator
// Assumes: clear time shortened to 8 cycles
// Notes: a monitor tallies drive activity
`timescale 1ns/10ps
`include "hbpg_defines.vh"
module hbpg_generator_tb;
  localparam CLR = 8;
  reg clk;
  reg reset;
  reg [3:0] addr;
  reg [31:0] writeData;
  reg writeStrobe;
  reg readStrobe;
  reg faultCond;
  reg highQ;
  reg lowQ;
  wire [31:0] readData;
  wire faultLineN;
  wire rdyLevel;
  wire rdyOeN;
  wire highDrive;
  wire lowDrive;
  wire irq;
  wire readyLine = rdyOeN ? 1'b1 : rdyLevel;
  integer mismatches;
  integer n_checks;
  integer highOn, lowOn, highRise, lowRise, h0, l0, hr0, lr0;
  hbpg_generator #(.CLEAR_CYCLES(CLR)) u_dut (
    .clk(clk), .reset(reset), .addr(addr), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData), .fault_line_n(faultLineN),
    .ready_clear_line(rdyLevel), .ready_clear_line_oe_n(rdyOeN), .high_side_drive(highDrive),
    .low_side_drive(lowDrive), .irq(irq));
  hbpg_gate_driver_model #(.MIN_CLEAR(CLR)) u_drv (
    .clk(clk), .faultCond(faultCond), .readyLine(readyLine), .fault_line_n(faultLineN));
  always @(posedge clk) begin
    highOn <= highOn + (highDrive === 1'b1);
    lowOn <= lowOn + (lowDrive === 1'b1);
    highRise <= highRise + (highDrive === 1'b1 && highQ !== 1'b1);
    lowRise <= lowRise + (lowDrive === 1'b1 && lowQ !== 1'b1);
    highQ <= highDrive;
    lowQ <= lowDrive;
  end
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clk);
      writeStrobe <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      readStrobe <= 1'b1;
      @(posedge clk);
      readStrobe <= 1'b0;
      #1 d = readData;
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task snap;
    begin
      h0 = highOn;
      l0 = lowOn;
      hr0 = highRise;
      lr0 = lowRise;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task test_static;
    integer i;
    reg [31:0] v;
    begin
      check("resetOff", {highDrive, lowDrive}, 32'h0);
      rd(4'hF, v);
      check("unmapped", v, 32'h0);
      for (i = 0; i < 4; i = i + 1) begin
        wr(`HBPG_REG_CTRL, i * 4 + 1);
        idle(3);
        check("staticHigh", highDrive, i[0]);
        check("staticLow", lowDrive, i[1]);
      end
      wr(`HBPG_REG_CTRL, 32'h0);
      idle(3);
      check("offBoth", {highDrive, lowDrive}, 32'h0);
      $display("test_static done");
    end
  endtask
  task test_double;
    integer i;
    reg [31:0] v;
    begin
      wr(`HBPG_REG_PULSE_A, 32'h3);
      wr(`HBPG_REG_PAUSE, 32'h2);
      wr(`HBPG_REG_PULSE_B, 32'h4);
      for (i = 0; i < 4; i = i + 1) begin
        wr(`HBPG_REG_CTRL, i * 16 + 2);
        snap;
        wr(`HBPG_REG_CMD, 32'h1);
        wr(`HBPG_REG_CMD, 32'h1);
        idle(30);
        check("pulseOn", i[0] ? highOn - h0 : lowOn - l0, i[1] ? 2 : 7);
        check("pulseRise", i[0] ? highRise - hr0 : lowRise - lr0, i[1] ? 1 : 2);
        check("otherOff", i[0] ? lowOn - l0 : highOn - h0, 0);
      end
      rd(`HBPG_REG_IRQ_STAT, v);
      check("doneIrq", v[1], 1'b1);
      wr(`HBPG_REG_IRQ_STAT, 32'h7);
      wr(`HBPG_REG_CTRL, 32'h0);
      $display("test_double done");
    end
  endtask
  task test_pwm;
    begin
      wr(`HBPG_REG_PERIOD, 32'h14);
      wr(`HBPG_REG_DUTY, 32'h8);
      wr(`HBPG_REG_DEAD, 32'h2);
      wr(`HBPG_REG_CTRL, 32'h3);
      wr(`HBPG_REG_CMD, 32'h2);
      idle(40);
      snap;
      idle(100);
      check("pwmHigh", highOn - h0, 30);
      check("pwmLow", lowOn - l0, 50);
      check("pwmRise", highRise - hr0, 5);
      wr(`HBPG_REG_CMD, 32'h4);
      idle(6);
      check("stopOff", {highDrive, lowDrive}, 32'h0);
      $display("test_pwm done");
    end
  endtask
  task test_fault;
    reg [31:0] v;
    begin
      wr(`HBPG_REG_IRQ_MASK, 32'h0);
      wr(`HBPG_REG_CMD, 32'h2);
      idle(30);
      @(posedge clk);
      faultCond <= 1'b1;
      idle(8);
      check("faultOff", {highDrive, lowDrive}, 32'h0);
      check("irqMasked", irq, 1'b0);
      wr(`HBPG_REG_IRQ_MASK, 32'h7);
      idle(1);
      check("irqRaised", irq, 1'b1);
      rd(`HBPG_REG_STATUS, v);
      check("lockout", v[4], 1'b1);
      wr(`HBPG_REG_CMD, 32'h8);
      idle(1);
      check("clearLow", readyLine, 1'b0);
      idle(CLR + 6);
      check("refault", faultLineN, 1'b0);
      @(posedge clk);
      faultCond <= 1'b0;
      wr(`HBPG_REG_CMD, 32'h8);
      idle(CLR + 6);
      check("cleared", faultLineN, 1'b1);
      rd(`HBPG_REG_IRQ_STAT, v);
      check("clearIrq", v[2], 1'b1);
      check("faultIrq", v[0], 1'b1);
      wr(`HBPG_REG_IRQ_STAT, 32'h7);
      idle(1);
      check("irqClear", irq, 1'b0);
      wr(`HBPG_REG_CTRL, 32'h3);
      snap;
      wr(`HBPG_REG_CMD, 32'h2);
      idle(40);
      check("lockedRun", highOn - h0, 0);
      wr(`HBPG_REG_CTRL, 32'h2);
      snap;
      wr(`HBPG_REG_CMD, 32'h1);
      idle(20);
      check("lockedTrig", lowOn - l0, 0);
      wr(`HBPG_REG_CTRL, 32'h0);
      wr(`HBPG_REG_CTRL, 32'h3);
      wr(`HBPG_REG_CMD, 32'h2);
      idle(40);
      check("rerun", highRise - hr0 > 0, 1);
      wr(`HBPG_REG_CMD, 32'h4);
      $display("test_fault done");
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    addr = 4'h0;
    writeData = 32'h0;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    faultCond = 1'b0;
    mismatches = 0;
    n_checks = 0;
    highOn = 0;
    lowOn = 0;
    highRise = 0;
    lowRise = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    idle(1);
    test_static;
    test_double;
    test_pwm;
    test_fault;
    conclude;
  end
  initial begin
    #(25 * 20000);
    mismatches = mismatches + 1;
    conclude;
  end
endmodule
